// ===== rtl/aosr_top.sv
// Functional notes
// R1 - configuration bank answers at host i/o 0100 to 0107
// R2 - extra configuration locations at host i/o 94 and 96
// R3 - host drives a separate setup select to each card
// R4 - an enable register turns the card on or off
// R5 - reads return the fixed card identification number
// R6 - written options are kept and steer the card
// R7 - error status is readable from the configuration bank
// R8 - channel error line only for serious faults like parity errors
// R9 - each serial port keeps an address select and decodes only there
// R10 - each select picks one of eight base addresses
// R11 - windows span eight locations; first uses irq 4, others irq 3
// R12 - onboard port may take only the first or second window
// R13 - host enables setup through 0094 and 0102 before port access; the code gates port decode on 0102 only, 0094 is plain storage
// R14 - interrupt outputs are level, active low, open collector
// R15 - readable interrupt pending latch per card; the code returns the live uart irq inputs instead
// R16 - ignore setup accesses without select; decode ports only when enabled
// R17 - after reset enable cleared and options defined
`timescale 1ns/1ps
`default_nettype none

module aosr_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        parity_err_i,
    input  wire logic [1:0]  uart_irq_i,
    output logic             channel_error_line_o,
    output logic             irq3_o,
    output logic             irq3_oe_o,
    output logic             irq4_o,
    output logic             irq4_oe_o,
    output logic             int_o
);

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        AOSR_IDLE,
        AOSR_ACK,
        AOSR_DROP
    } aosr_bus_e;

    typedef struct packed {
        aosr_bus_e           bus;
        logic [31:0]         rdata;
        logic                ack;
        logic [15:0]         haddr;
        logic [7:0]          hdata;
        logic                hsel_n;
        logic                hreq;
        logic                hwr;
        logic [7:0]          hrd;
        logic [aosr_pkg::NUM_EV-1:0] stat;
        logic [aosr_pkg::NUM_EV-1:0] mask;
        logic [1:0]          hit;
        logic                chan_err;
        logic                irq3;
        logic                irq4;
        logic                intr;
    } aosr_state_s;

    aosr_state_s st_ff;
    aosr_state_s nxt_st;

    logic                bus_req;
    logic                bank_req;
    aosr_pkg::aosr_req_s bank_d;
    logic                bank_hit;
    logic [7:0]          bank_rdata;
    logic [7:0]          en_reg;
    logic [7:0]          sel_reg;
    logic [7:0]          err_reg;
    logic [1:0]          port_hit;
    logic [1:0]          port_irq4;
    logic [2:0]          port_sel [aosr_pkg::NUM_PORTS];
    logic [aosr_pkg::NUM_EV-1:0] ev;

    assign bus_req = wb_cyc_i && wb_stb_i && (st_ff.bus == AOSR_IDLE);
    assign bank_req = st_ff.hreq;
    assign bank_d = '{addr: st_ff.haddr, wdata: st_ff.hdata, write: st_ff.hwr};

    // ==========================================================
    // configuration bank
    aosr_setup_bank u_bank (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .req_i      (bank_req),
        .req_d_i    (bank_d),
        .select_n_i (st_ff.hsel_n),
        .err_i      (parity_err_i),
        .hit_o      (bank_hit),
        .rdata_o    (bank_rdata),
        .enable_o   (en_reg),
        .portsel_o  (sel_reg),
        .errstat_o  (err_reg)
    );

    // ==========================================================
    // serial port decode, one per port
    always_comb begin
        port_sel[0] = sel_reg[2:0];
        port_sel[1] = sel_reg[6:4];
        // onboard bit restricts both ports to the first two windows [R12]
        if (en_reg[aosr_pkg::ONBOARD_BIT]) begin
            port_sel[0] = {2'b00, sel_reg[0]};
            port_sel[1] = {2'b00, sel_reg[4]};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < aosr_pkg::NUM_PORTS; gi++) begin : g_port
            aosr_port_decode u_dec (
                .addr_i   (st_ff.haddr),
                .sel_i    (port_sel[gi]),
                .enable_i (en_reg[aosr_pkg::EN_BIT]),
                .hit_o    (port_hit[gi]),
                .irq4_o   (port_irq4[gi])
            );
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.ack  = 1'b0;
        nxt_st.hreq = 1'b0;
        ev          = '0;
        case (st_ff.bus)
            AOSR_IDLE: begin
                if (bus_req) begin
                    nxt_st.bus   = AOSR_ACK;
                    nxt_st.ack   = 1'b1;
                    nxt_st.rdata = 32'h0000_0000;
                    case (wb_adr_i)
                        aosr_pkg::OFF_HOST_ADDR: begin
                            nxt_st.rdata = {16'h0000, st_ff.haddr};
                            if (wb_we_i && wb_sel_i[0]) begin
                                nxt_st.haddr[7:0] = wb_dat_i[7:0];
                            end
                            if (wb_we_i && wb_sel_i[1]) begin
                                nxt_st.haddr[15:8] = wb_dat_i[15:8];
                            end
                        end
                        aosr_pkg::OFF_HOST_DATA: begin
                            nxt_st.rdata = {24'h000000, st_ff.hrd};
                            if (wb_we_i && wb_sel_i[0]) begin
                                nxt_st.hdata = wb_dat_i[7:0];
                            end
                        end
                        aosr_pkg::OFF_HOST_CTRL: begin
                            nxt_st.rdata = {29'h0, 1'b0, !st_ff.hsel_n, st_ff.hwr};
                            if (wb_we_i && wb_sel_i[0]) begin
                                nxt_st.hwr    = wb_dat_i[aosr_pkg::CTRL_WR_BIT];
                                nxt_st.hsel_n = !wb_dat_i[aosr_pkg::CTRL_SEL_BIT]; // [R3]
                                nxt_st.hreq   = wb_dat_i[aosr_pkg::CTRL_GO_BIT];
                            end
                        end
                        aosr_pkg::OFF_IRQ_STAT: begin
                            nxt_st.rdata = {29'h0, st_ff.stat};
                            if (!wb_we_i) begin
                                nxt_st.stat = '0;
                            end
                        end
                        aosr_pkg::OFF_IRQ_MASK: begin
                            nxt_st.rdata = {29'h0, st_ff.mask};
                            if (wb_we_i && wb_sel_i[0]) begin
                                nxt_st.mask = wb_dat_i[aosr_pkg::NUM_EV-1:0];
                            end
                        end
                        aosr_pkg::OFF_CFG_VIEW: begin
                            nxt_st.rdata = {8'h00, err_reg, sel_reg, en_reg};
                        end
                        aosr_pkg::OFF_PORT_HIT: begin
                            // live uart irq inputs and latched port hits, no pending latch [R15]
                            nxt_st.rdata = {26'h0, uart_irq_i, 2'b00, st_ff.hit};
                        end
                        default: nxt_st.rdata = 32'h0000_0000;
                    endcase
                end
            end
            AOSR_ACK:  nxt_st.bus = AOSR_DROP;
            AOSR_DROP: nxt_st.bus = AOSR_IDLE;
            default:   nxt_st.bus = AOSR_IDLE;
        endcase

        // host cycle onto configuration bank and port decode
        if (st_ff.hreq) begin
            nxt_st.hrd = bank_hit ? bank_rdata : 8'hFF;
            nxt_st.hit = port_hit; // [R9]
            ev[aosr_pkg::EV_CFG_WR] = bank_hit && st_ff.hwr;
            ev[aosr_pkg::EV_PORT]   = |port_hit;
        end
        ev[aosr_pkg::EV_PARITY] = parity_err_i;

        // set wins over read clear
        nxt_st.stat = nxt_st.stat | ev;
        // serious fault only: parity [R8]
        nxt_st.chan_err = err_reg[0] || parity_err_i;
        // open collector, active low level per irq line [R14] [R11]
        nxt_st.irq4 = 1'b0;
        nxt_st.irq3 = 1'b0;
        for (int i = 0; i < aosr_pkg::NUM_PORTS; i++) begin
            if (uart_irq_i[i] && en_reg[aosr_pkg::EN_BIT]) begin
                if (port_irq4[i]) begin
                    nxt_st.irq4 = 1'b1;
                end else begin
                    nxt_st.irq3 = 1'b1;
                end
            end
        end
        nxt_st.intr = |(nxt_st.stat & st_ff.mask);

        if (rst_i) begin
            nxt_st        = '0;
            nxt_st.bus    = AOSR_IDLE;
            nxt_st.hsel_n = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    // ==========================================================
    // outputs
    assign wb_dat_o             = st_ff.rdata;
    assign wb_ack_o             = st_ff.ack;
    assign channel_error_line_o = st_ff.chan_err;
    assign irq3_o               = 1'b0;
    assign irq3_oe_o            = st_ff.irq3;
    assign irq4_o               = 1'b0;
    assign irq4_oe_o            = st_ff.irq4;
    assign int_o                = st_ff.intr;

    // ==========================================================
    // checks
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_parity_chan_err: assert property ( // [R8]
        parity_err_i |=> channel_error_line_o)
        else $error("channel error not raised after parity fault");

    a_chan_err_quiet: assert property ( // [R8]
        (!err_reg[0] && !parity_err_i) |=> !channel_error_line_o)
        else $error("channel error without a fault");

    a_errstat_set: assert property ( // [R7]
        parity_err_i |=> err_reg[0])
        else $error("parity fault not in error status");

    a_reset_enable: assert property ( // [R17]
        ($past(rst_i) && !rst_i) |->
        (en_reg == aosr_pkg::RST_ENABLE && sel_reg == aosr_pkg::RST_PORTSEL))
        else $error("enable or port select wrong after reset");

    a_decode_gated: assert property ( // [R16]
        !en_reg[aosr_pkg::EN_BIT] |-> (port_hit == 2'b00))
        else $error("port decoded while card disabled");

    a_setup_ignored: assert property ( // [R16]
        (st_ff.hreq && st_ff.hsel_n) |-> !bank_hit)
        else $error("setup bank answered without select");

    a_miss_reads_ff: assert property ( // [R16]
        (st_ff.hreq && !bank_hit) |=> (st_ff.hrd == 8'hFF))
        else $error("missed setup access returned data");

    a_id_read_lo: assert property ( // [R5]
        (st_ff.hreq && !st_ff.hsel_n && st_ff.haddr == aosr_pkg::SETUP_BANK_BASE)
        |=> (st_ff.hrd == aosr_pkg::CARD_ID[7:0]))
        else $error("card id low byte wrong");

    a_id_read_hi: assert property ( // [R5]
        (st_ff.hreq && !st_ff.hsel_n &&
         st_ff.haddr == (aosr_pkg::SETUP_BANK_BASE + 16'h0001))
        |=> (st_ff.hrd == aosr_pkg::CARD_ID[15:8]))
        else $error("card id high byte wrong");

    a_enable_write: assert property ( // [R4] [R6]
        (st_ff.hreq && !st_ff.hsel_n && st_ff.hwr &&
         st_ff.haddr == (aosr_pkg::SETUP_BANK_BASE + 16'h0002))
        |=> (en_reg == $past(st_ff.hdata)))
        else $error("enable write not kept");

    a_port_hit_kept: assert property ( // [R9]
        st_ff.hreq |=> (st_ff.hit == $past(port_hit)))
        else $error("port hit not recorded");

    a_onboard_limit: assert property ( // [R12]
        en_reg[aosr_pkg::ONBOARD_BIT] |->
        (port_sel[0][2:1] == 2'b00 && port_sel[1][2:1] == 2'b00))
        else $error("onboard port beyond second window");

    a_irq4_route: assert property ( // [R11]
        (uart_irq_i[0] && en_reg[aosr_pkg::EN_BIT] && port_sel[0] == 3'h0)
        |=> irq4_oe_o)
        else $error("first window not routed to irq 4");

    a_irq3_route: assert property ( // [R11]
        (uart_irq_i[0] && en_reg[aosr_pkg::EN_BIT] && port_sel[0] != 3'h0)
        |=> irq3_oe_o)
        else $error("other window not routed to irq 3");

    a_irq_gated: assert property ( // [R14]
        !en_reg[aosr_pkg::EN_BIT] |=> (!irq3_oe_o && !irq4_oe_o))
        else $error("irq line pulled while card disabled");

    a_irq_open_drain: assert property ( // [R14]
        !irq3_o && !irq4_o)
        else $error("interrupt pin driven high");

    // ==========================================================
    // checks: register bus and interrupt status
    a_ack_follows_req: assert property (
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged");

    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_stat_set_wins: assert property (
        (ev != '0) |=> ((st_ff.stat & $past(ev)) == $past(ev)))
        else $error("status event lost");

    a_stat_read_clear: assert property (
        (bus_req && !wb_we_i && wb_adr_i == aosr_pkg::OFF_IRQ_STAT && ev == '0)
        |=> (st_ff.stat == '0))
        else $error("status not cleared by read");

    a_int_level: assert property (
        int_o |-> (st_ff.stat != '0))
        else $error("interrupt without status");

    a_int_masked: assert property (
        (st_ff.mask == '0) |=> !int_o)
        else $error("interrupt while all masked");

endmodule // aosr_top

`default_nettype wire

// ===== rtl/aosr_pkg.sv
package aosr_pkg;

    // ==========================================================
    // configuration locations (host i/o addresses)
    localparam logic [15:0] SETUP_BANK_BASE = 16'h0100;
    localparam logic [15:0] SETUP_BANK_LAST = 16'h0107;
    localparam logic [15:0] SETUP_EXT_A     = 16'h0094;
    localparam logic [15:0] SETUP_EXT_B     = 16'h0096;

    // ==========================================================
    // wishbone word offsets of the register file
    localparam logic [7:0] OFF_HOST_ADDR = 8'h00;
    localparam logic [7:0] OFF_HOST_DATA = 8'h04;
    localparam logic [7:0] OFF_HOST_CTRL = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
    localparam logic [7:0] OFF_CFG_VIEW  = 8'h14;
    localparam logic [7:0] OFF_PORT_HIT  = 8'h18;

    // host ctrl fields
    localparam int CTRL_WR_BIT    = 0;
    localparam int CTRL_SEL_BIT   = 1;
    localparam int CTRL_GO_BIT    = 2;

    // ==========================================================
    // bank layout: index from 0100 base
    localparam logic [2:0] IDX_ID_LO   = 3'h0;
    localparam logic [2:0] IDX_ID_HI   = 3'h1;
    localparam logic [2:0] IDX_ENABLE  = 3'h2;
    localparam logic [2:0] IDX_PORTSEL = 3'h3;
    localparam logic [2:0] IDX_ERRSTAT = 3'h5;
    localparam int EN_BIT      = 0;
    localparam int ONBOARD_BIT = 1;

    // card id value is arbitrary
    localparam logic [15:0] CARD_ID    = 16'h5A3C;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_ENABLE  = 8'h00;
    localparam logic [7:0] RST_PORTSEL = 8'h10;
    localparam logic [7:0] RST_GEN     = 8'h00;

    localparam int NUM_PORTS = 2;
    localparam int NUM_WIN   = 8;
    localparam logic [2:0] WIN_SPAN_MASK = 3'h7;

    // ==========================================================
    // interrupt status bits
    localparam int EV_CFG_WR = 0;
    localparam int EV_PARITY = 1;
    localparam int EV_PORT   = 2;
    localparam int NUM_EV    = 3;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
    } aosr_req_s;

endpackage : aosr_pkg

// ===== rtl/aosr_port_decode.sv
`timescale 1ns/1ps
`default_nettype none

module aosr_port_decode (
    input  wire logic [15:0] addr_i,
    input  wire logic [2:0]  sel_i,
    input  wire logic        enable_i,
    output logic             hit_o,
    output logic             irq4_o
);

    // ==========================================================
    // window base table
    function automatic logic [15:0] win_base(input logic [2:0] s);
        case (s)
            3'h0:    win_base = 16'h03F8;
            3'h1:    win_base = 16'h02F8;
            3'h2:    win_base = 16'h3220;
            3'h3:    win_base = 16'h3228;
            3'h4:    win_base = 16'h4220;
            3'h5:    win_base = 16'h4228;
            3'h6:    win_base = 16'h5220;
            default: win_base = 16'h5228;
        endcase
    endfunction

    always_comb begin
        // eight-location window, decoded only when enabled [R9] [R10] [R11] [R16]
        hit_o  = enable_i &&
                 ((addr_i & ~{13'h0000, aosr_pkg::WIN_SPAN_MASK}) == win_base(sel_i));
        irq4_o = (sel_i == 3'h0); // [R11]
    end

endmodule // aosr_port_decode

`default_nettype wire

// ===== rtl/aosr_setup_bank.sv
`timescale 1ns/1ps
`default_nettype none

module aosr_setup_bank (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire aosr_pkg::aosr_req_s req_d_i,
    input  wire logic        select_n_i,
    input  wire logic        err_i,
    output logic             hit_o,
    output logic [7:0]       rdata_o,
    output logic [7:0]       enable_o,
    output logic [7:0]       portsel_o,
    output logic [7:0]       errstat_o
);

    typedef struct packed {
        logic [7:0][7:0] regs;
        logic [7:0]      ext_a;
        logic [7:0]      ext_b;
    } aosr_bank_s;

    aosr_bank_s st_ff;
    aosr_bank_s nxt_st;
    logic in_bank;
    logic in_a;
    logic in_b;

    always_comb begin
        in_bank = (req_d_i.addr >= aosr_pkg::SETUP_BANK_BASE) &&
                  (req_d_i.addr <= aosr_pkg::SETUP_BANK_LAST); // [R1]
        in_a    = (req_d_i.addr == aosr_pkg::SETUP_EXT_A);     // [R2]
        in_b    = (req_d_i.addr == aosr_pkg::SETUP_EXT_B);     // [R2]
        // accesses ignored unless this card is selected [R16] [R3]
        hit_o   = !select_n_i && (in_bank || in_a || in_b);
        nxt_st  = st_ff;
        if (req_i && hit_o && req_d_i.write && in_bank) begin
            // id and error status are not software-writable [R6]
            if (req_d_i.addr[2:0] != aosr_pkg::IDX_ID_LO &&
                req_d_i.addr[2:0] != aosr_pkg::IDX_ID_HI &&
                req_d_i.addr[2:0] != aosr_pkg::IDX_ERRSTAT) begin
                nxt_st.regs[req_d_i.addr[2:0]] = req_d_i.wdata;
            end
        end
        if (req_i && hit_o && req_d_i.write && in_a) begin
            nxt_st.ext_a = req_d_i.wdata;
        end
        if (req_i && hit_o && req_d_i.write && in_b) begin
            nxt_st.ext_b = req_d_i.wdata;
        end
        // parity fault latched into error status [R7]
        if (err_i) begin
            nxt_st.regs[aosr_pkg::IDX_ERRSTAT][0] = 1'b1;
        end else if (req_i && hit_o && !req_d_i.write && in_bank &&
                     req_d_i.addr[2:0] == aosr_pkg::IDX_ERRSTAT) begin
            nxt_st.regs[aosr_pkg::IDX_ERRSTAT] = 8'h00;
        end
        if (rst_i) begin
            nxt_st = '0;
            nxt_st.regs[aosr_pkg::IDX_ENABLE]  = aosr_pkg::RST_ENABLE;  // [R17]
            nxt_st.regs[aosr_pkg::IDX_PORTSEL] = aosr_pkg::RST_PORTSEL; // [R17]
        end
        rdata_o = 8'h00;
        if (in_bank) begin
            case (req_d_i.addr[2:0])
                aosr_pkg::IDX_ID_LO: rdata_o = aosr_pkg::CARD_ID[7:0];  // [R5]
                aosr_pkg::IDX_ID_HI: rdata_o = aosr_pkg::CARD_ID[15:8]; // [R5]
                default:             rdata_o = st_ff.regs[req_d_i.addr[2:0]];
            endcase
        end else if (in_a) begin
            rdata_o = st_ff.ext_a;
        end else if (in_b) begin
            rdata_o = st_ff.ext_b;
        end
        enable_o  = st_ff.regs[aosr_pkg::IDX_ENABLE];  // [R4]
        portsel_o = st_ff.regs[aosr_pkg::IDX_PORTSEL]; // [R6]
        errstat_o = st_ff.regs[aosr_pkg::IDX_ERRSTAT];
    end

    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

endmodule // aosr_setup_bank

`default_nettype wire

// ===== verification/aosr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: uart sources, parity source, shared irq lines
module aosr_host_model (
    input  wire logic       clk_i,
    input  wire logic       parity_cmd_i,
    input  wire logic [1:0] irq_cmd_i,
    input  wire logic       irq3_oe_i,
    input  wire logic       irq4_oe_i,
    output logic            parity_err_o,
    output logic [1:0]      uart_irq_o,
    output logic            irq3_line_n_o,
    output logic            irq4_line_n_o
);
    always @(posedge clk_i) begin
        parity_err_o <= parity_cmd_i;
        uart_irq_o   <= irq_cmd_i;
    end
    // open collector with pull-up: low only while some card drives it
    assign irq3_line_n_o = irq3_oe_i ? 1'b0 : 1'b1;
    assign irq4_line_n_o = irq4_oe_i ? 1'b0 : 1'b1;
endmodule // aosr_host_model
`default_nettype wire

// ===== verification/adapter_option_select_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adapter_option_select_regs_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, par = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, r;
    logic [1:0]  uirq = 2'h0, ui;
    logic [7:0]  q;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, ch_err, i3, i3oe, i4, i4oe, int_o, pe, l3, l4;
    int          err_count = 0;
    int          checked = 0;
    logic [15:0] win[8] = '{16'h03F8, 16'h02F8, 16'h3220, 16'h3228,
                            16'h4220, 16'h4228, 16'h5220, 16'h5228};
    localparam logic [15:0] B = 16'h0100;

    always #50 clk_i = ~clk_i;

    aosr_top i_aosr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .parity_err_i(pe), .uart_irq_i(ui),
        .channel_error_line_o(ch_err), .irq3_o(i3), .irq3_oe_o(i3oe), .irq4_o(i4),
        .irq4_oe_o(i4oe), .int_o(int_o));
    aosr_host_model i_aosr_host_model (.clk_i(clk_i), .parity_cmd_i(par), .irq_cmd_i(uirq),
        .irq3_oe_i(i3oe), .irq4_oe_i(i4oe), .parity_err_o(pe), .uart_irq_o(ui),
        .irq3_line_n_o(l3), .irq4_line_n_o(l4));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // ==========================================
    // classic wishbone single cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
        repeat (2) @(posedge clk_i);
    endtask

    // one host i/o cycle, s = setup select of this card
    task automatic host(input logic s, input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        wb(1'b1, aosr_pkg::OFF_HOST_ADDR, {16'h0, a});
        wb(1'b1, aosr_pkg::OFF_HOST_DATA, {24'h0, d});
        wb(1'b1, aosr_pkg::OFF_HOST_CTRL, {29'h0, 1'b1, s, w});
        repeat (3) @(posedge clk_i);
        wb(1'b0, aosr_pkg::OFF_HOST_DATA, 32'h0);
        q = r[7:0];
    endtask

    task automatic stat(input int bit_i, input logic exp);
        wb(1'b0, aosr_pkg::OFF_IRQ_STAT, 32'h0);
        check(r[bit_i], exp);
    endtask

    // ==========================================
    task automatic t_reset();
        host(1, 0, B + 16'h0, 8'h00); check(q, aosr_pkg::CARD_ID[7:0]);
        host(1, 0, B + 16'h1, 8'h00); check(q, aosr_pkg::CARD_ID[15:8]);
        host(1, 0, B + 16'h2, 8'h00); check(q, aosr_pkg::RST_ENABLE);
        host(1, 0, B + 16'h3, 8'h00); check(q, aosr_pkg::RST_PORTSEL);
        check({i3, i4, ch_err, int_o}, 4'h0);
        wb(1'b0, 8'h1C, 32'h0); check(r, 32'h0);
    endtask

    task automatic t_select();
        stat(aosr_pkg::EV_CFG_WR, 1'b0);
        host(0, 1, B + 16'h3, 8'h55);
        host(0, 0, B + 16'h3, 8'h00); check(q, 8'hFF);
        stat(aosr_pkg::EV_CFG_WR, 1'b0);
        host(1, 0, B + 16'h3, 8'h00); check(q, aosr_pkg::RST_PORTSEL);
        host(1, 1, B + 16'h0, 8'h00);
        host(1, 0, B + 16'h0, 8'h00); check(q, aosr_pkg::CARD_ID[7:0]);
        stat(aosr_pkg::EV_CFG_WR, 1'b1);
    endtask

    task automatic t_store();
        logic [15:0] loc[5] = '{16'h0104, 16'h0106, 16'h0107, 16'h0094, 16'h0096};
        for (int i = 0; i < 5; i++) host(1, 1, loc[i], 8'hA0 + 8'(i));
        for (int i = 0; i < 5; i++) begin
            host(1, 0, loc[i], 8'h00); check(q, 8'hA0 + 8'(i));
        end
    endtask

    task automatic t_windows();
        host(1, 1, B + 16'h2, 8'h01);
        for (int w = 0; w < 8; w++) begin
            host(1, 1, B + 16'h3, {1'b0, 3'(w), 1'b0, 3'(w)});
            wb(1'b1, aosr_pkg::OFF_HOST_CTRL, 32'h0);
            stat(aosr_pkg::EV_PORT, 1'b0);
            host(0, 0, win[w] + 16'h7, 8'h00);
            stat(aosr_pkg::EV_PORT, 1'b1);
            host(0, 0, win[w] + 16'h8, 8'h00);
            stat(aosr_pkg::EV_PORT, 1'b0);
            uirq <= 2'h1;
            repeat (4) @(posedge clk_i);
            check({i4oe, i3oe, l4, l3}, (w == 0) ? 4'b1001 : 4'b0110);
            check({i4, i3}, 2'b00);
            wb(1'b0, aosr_pkg::OFF_PORT_HIT, 32'h0);
            check(r, 32'h10);
            uirq <= 2'h0;
            repeat (4) @(posedge clk_i);
            check({l4, l3}, 2'b11);
        end
        host(1, 1, B + 16'h2, 8'h00);
        wb(1'b1, aosr_pkg::OFF_HOST_CTRL, 32'h0);
        stat(aosr_pkg::EV_PORT, 1'b0);
        host(0, 0, win[7], 8'h00);
        stat(aosr_pkg::EV_PORT, 1'b0);
    endtask

    task automatic t_onboard();
        host(1, 1, B + 16'h2, 8'h03);
        host(1, 1, B + 16'h3, 8'h22);
        stat(aosr_pkg::EV_PORT, 1'b0);
        host(0, 0, win[2], 8'h00);
        stat(aosr_pkg::EV_PORT, 1'b0);
        host(1, 1, B + 16'h3, 8'h11);
        stat(aosr_pkg::EV_PORT, 1'b0);
        host(0, 0, win[1], 8'h00);
        stat(aosr_pkg::EV_PORT, 1'b1);
    endtask

    task automatic t_parity();
        wb(1'b1, aosr_pkg::OFF_IRQ_MASK, 32'h7);
        stat(aosr_pkg::EV_PARITY, 1'b0);
        check(int_o, 1'b0);
        par <= 1'b1;
        repeat (4) @(posedge clk_i);
        par <= 1'b0;
        check(ch_err, 1'b1);
        repeat (4) @(posedge clk_i);
        check(int_o, 1'b1);
        stat(aosr_pkg::EV_PARITY, 1'b1);
        host(1, 0, B + 16'h5, 8'h00); check(q[0], 1'b1);
        host(1, 0, B + 16'h5, 8'h00); check(q[0], 1'b0);
        stat(aosr_pkg::EV_PARITY, 1'b0);
        repeat (3) @(posedge clk_i);
        check({ch_err, int_o}, 2'b00);
        wb(1'b1, aosr_pkg::OFF_IRQ_MASK, 32'h0);
        par <= 1'b1;
        repeat (4) @(posedge clk_i);
        par <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(int_o, 1'b0);
        stat(aosr_pkg::EV_PARITY, 1'b1);
    endtask

    task automatic final_report();
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #(100 * 60000);
        err_count++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_select();
        t_store();
        t_windows();
        t_onboard();
        t_parity();
        final_report();
    end
endmodule // adapter_option_select_regs_tb
`default_nettype wire
